// >>> src/fcsc_top.sv
// Clock source control registers, reference handling and mode logic
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module fcsc_top (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        intRefClkIn,
   input  wire logic        extRefClkIn,
   input  wire logic        fllOutTick,
   input  wire logic        stopMode,
   input  wire logic        backgroundDebugActive,
   output logic             fllRefTick,
   output logic             fllRefInternal,
   output logic             fllEnable,
   output logic [9:0]       fllLockRatio,
   output logic             internalRefRun,
   output logic             internalRefClkOut,
   output logic             extRefRun,
   output logic             extRefClkOut,
   output logic             oscRangeHigh,
   output logic             oscHighGain,
   output logic             oscSelect,
   output logic             systemClkTick,
   output logic             busClkTick,
   output logic [2:0]       clockMode
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0]             ctrlOne;
      logic [7:0]             ctrlTwo;
      logic                   ack;
      logic [7:0]             rdData;
      logic [2:0]             intSync;
      logic [2:0]             extSync;
      logic [6:0]             refCnt;
      logic                   fllRefTick;
      logic                   fllEn;
      logic                   intTk;
      logic                   extTk;
      logic                   irOut;
      logic                   erOut;
      logic                   intRun;
      logic                   extRun;
      fcsc_pkg::fcsc_mode_t   mode;
      logic                   stopPrev;
      logic                   wasInt;
      logic                   wasExt;
   } fcsc_top_t;

   // Out of reset: FLL engaged internal, bus divider at 01
   localparam fcsc_top_t TOP_RST = '{
      fcsc_pkg::CTRL_ONE_RST, fcsc_pkg::CTRL_TWO_RST, 1'b0, 8'h00, 3'h0, 3'h0, 7'h00,
      1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, fcsc_pkg::MODE_FEI,
      1'b0, 1'b0, 1'b0};

   fcsc_top_t           st_reg;
   fcsc_top_t           st_next;
   fcsc_pkg::fcsc_src_t src;
   fcsc_pkg::fcsc_mode_t modeNow;
   logic                internal_ref_select;
   logic                lowPowerByp;
   logic                intEdge;
   logic                extEdge;
   logic                stopEntry;
   logic                wasIntNow;
   logic                wasExtNow;
   logic                refTick;
   logic                bypassBoth;
   logic [6:0]          refLim;
   logic                busReq;
   logic                wrHit;

   fcsc_clk_if clkIf ();

   function automatic logic mode_is_int(input fcsc_pkg::fcsc_mode_t m);
      return (m == fcsc_pkg::MODE_FEI) || (m == fcsc_pkg::MODE_FBI) ||
             (m == fcsc_pkg::MODE_FLL_BYPASSED_INTERNAL_LOW_POWER_MODE);
   endfunction : mode_is_int

   function automatic logic mode_is_ext(input fcsc_pkg::fcsc_mode_t m);
      return (m == fcsc_pkg::MODE_FEE) || (m == fcsc_pkg::MODE_FBE) ||
             (m == fcsc_pkg::MODE_FLL_BYPASSED_EXTERNAL_LOW_POWER_MODE);
   endfunction : mode_is_ext

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      st_next = st_reg;
      src = fcsc_pkg::src_of(st_reg.ctrlOne[fcsc_pkg::SRC_HI:fcsc_pkg::SRC_LO]);
      internal_ref_select = st_reg.ctrlOne[fcsc_pkg::IREF_SEL];
      lowPowerByp = st_reg.ctrlTwo[fcsc_pkg::BYP_LP] && !backgroundDebugActive;

      // Reference inputs come from oscillators asynchronous to core_clk
      st_next.intSync = {st_reg.intSync[1:0], intRefClkIn};
      st_next.extSync = {st_reg.extSync[1:0], extRefClkIn};
      intEdge = st_reg.intSync[1] && !st_reg.intSync[2];
      extEdge = st_reg.extSync[1] && !st_reg.extSync[2];

      // Mode follows the source encoding
      case (src)
         fcsc_pkg::SRC_INT:
            modeNow = lowPowerByp ? fcsc_pkg::MODE_FLL_BYPASSED_INTERNAL_LOW_POWER_MODE : fcsc_pkg::MODE_FBI;
         fcsc_pkg::SRC_EXT:
            modeNow = lowPowerByp ? fcsc_pkg::MODE_FLL_BYPASSED_EXTERNAL_LOW_POWER_MODE : fcsc_pkg::MODE_FBE;
         default:
            modeNow = internal_ref_select ? fcsc_pkg::MODE_FEI : fcsc_pkg::MODE_FEE;
      endcase
      if (stopMode)
         modeNow = fcsc_pkg::MODE_STOP;
      st_next.mode = modeNow;

      // Mode before stop is caught on the way in
      stopEntry = stopMode && !st_reg.stopPrev;
      wasIntNow = stopEntry ? mode_is_int(st_reg.mode) : st_reg.wasInt;
      wasExtNow = stopEntry ? mode_is_ext(st_reg.mode) : st_reg.wasExt;
      st_next.stopPrev = stopMode;
      st_next.wasInt = wasIntNow;
      st_next.wasExt = wasExtNow;

      if (stopMode)
      begin
         st_next.intRun = st_reg.ctrlOne[fcsc_pkg::IR_KEEP] &&
                          (st_reg.ctrlOne[fcsc_pkg::IR_EN] || wasIntNow);
         st_next.extRun = st_reg.ctrlTwo[fcsc_pkg::ER_KEEP] &&
                          (st_reg.ctrlTwo[fcsc_pkg::ER_EN] || wasExtNow);
      end
      else
      begin
         st_next.intRun = st_reg.ctrlOne[fcsc_pkg::IR_EN] || internal_ref_select || src == fcsc_pkg::SRC_INT;
         st_next.extRun = st_reg.ctrlTwo[fcsc_pkg::ER_EN] || !internal_ref_select ||
                          src == fcsc_pkg::SRC_EXT;
      end

      st_next.intTk = intEdge && st_reg.intRun;
      st_next.extTk = extEdge && st_reg.extRun;
      st_next.irOut = intEdge && st_reg.intRun && st_reg.ctrlOne[fcsc_pkg::IR_EN];
      st_next.erOut = extEdge && st_reg.extRun && st_reg.ctrlTwo[fcsc_pkg::ER_EN];

      // FLL keeps running until the output has really left it
      bypassBoth = (src != fcsc_pkg::SRC_FLL) && (clkIf.actSel != fcsc_pkg::SRC_FLL);
      st_next.fllEn = !stopMode && !(bypassBoth && lowPowerByp);

      // Reference pre-divider feeding the FLL
      refTick = internal_ref_select ? (intEdge && st_reg.intRun) : (extEdge && st_reg.extRun);
      refLim = fcsc_pkg::div_limit(st_reg.ctrlOne[fcsc_pkg::REFERENCE_DIVIDER_HI:fcsc_pkg::REFERENCE_DIVIDER_LO]);
      st_next.fllRefTick = 1'b0;
      if (!st_reg.fllEn)
      begin
         st_next.refCnt = 7'h00;
      end
      else if (refTick)
      begin
         if (st_reg.refCnt >= refLim)
         begin
            st_next.refCnt = 7'h00;
            st_next.fllRefTick = 1'b1;
         end
         else
         begin
            st_next.refCnt = st_reg.refCnt + 7'h01;
         end
      end

      // Avalon slave: one wait cycle, answer in the next
      busReq = avs_read || avs_write;
      wrHit = avs_write && st_reg.ack && avs_byteenable[0];
      st_next.ack = busReq && !st_reg.ack;
      if (busReq && !st_reg.ack)
      begin
         case (avs_address)
            fcsc_pkg::OFF_CTRL_ONE: st_next.rdData = st_reg.ctrlOne;
            fcsc_pkg::OFF_CTRL_TWO: st_next.rdData = st_reg.ctrlTwo;
            default:                st_next.rdData = 8'h00;
         endcase
      end
      if (wrHit && avs_address == fcsc_pkg::OFF_CTRL_ONE)
         st_next.ctrlOne = avs_writedata[7:0];
      if (wrHit && avs_address == fcsc_pkg::OFF_CTRL_TWO)
         st_next.ctrlTwo = avs_writedata[7:0];
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         st_reg <= TOP_RST;
      else
         st_reg <= st_next;
   end

   // ************************************************************
   // Output clock generator
   // ************************************************************
   assign clkIf.reqSel  = src;
   assign clkIf.reqDiv  = st_reg.ctrlTwo[fcsc_pkg::BUS_CLOCK_DIVIDER_HI:fcsc_pkg::BUS_CLOCK_DIVIDER_LO];
   assign clkIf.fllTick = fllOutTick && st_reg.fllEn;
   assign clkIf.intTick = st_reg.intTk;
   assign clkIf.extTick = st_reg.extTk;

   fcsc_clk_gen #(
      .CNT_W (3)
   ) fcsc_clk_gen_inst (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk      (clkIf)
   );

   // ************************************************************
   // Outputs, all on-chip
   // ************************************************************
   assign avs_waitrequest   = (avs_read || avs_write) && !st_reg.ack;
   assign avs_readdata      = {24'h000000, st_reg.rdData};
   assign fllRefTick        = st_reg.fllRefTick;
   assign fllRefInternal    = st_reg.ctrlOne[fcsc_pkg::IREF_SEL];
   assign fllEnable         = st_reg.fllEn;
   assign fllLockRatio      = fcsc_pkg::FLL_MULT;
   assign internalRefRun    = st_reg.intRun;
   assign internalRefClkOut = st_reg.irOut;
   assign extRefRun         = st_reg.extRun;
   assign extRefClkOut      = st_reg.erOut;
   assign oscRangeHigh      = st_reg.ctrlTwo[fcsc_pkg::RANGE_HI];
   assign oscHighGain       = st_reg.ctrlTwo[fcsc_pkg::GAIN_HI];
   assign oscSelect         = st_reg.ctrlTwo[fcsc_pkg::EXT_SRC];
   assign systemClkTick     = clkIf.sysTick;
   assign busClkTick        = clkIf.busTick;
   assign clockMode         = st_reg.mode;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence accTwo;
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == fcsc_pkg::OFF_CTRL_TWO;
   endsequence

   sequence rdOne;
      avs_read && !avs_waitrequest && avs_address == fcsc_pkg::OFF_CTRL_ONE;
   endsequence

   sequence accOne;
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == fcsc_pkg::OFF_CTRL_ONE;
   endsequence

   sequence laneOff;
      avs_write && !avs_waitrequest && !avs_byteenable[0];
   endsequence

   // Register writes land at the completion edge only
   writeOne_a: assert property (accOne |=> st_reg.ctrlOne == $past(avs_writedata[7:0]))
      else $error("control one not written");
   laneRefuse_a: assert property (laneOff |=>
      $stable(st_reg.ctrlOne) && $stable(st_reg.ctrlTwo))
      else $error("write with low lane disabled landed");

   // Mode decoding follows the source field
   rsvdSrc_a: assert property ((st_reg.ctrlOne[fcsc_pkg::SRC_HI:fcsc_pkg::SRC_LO] == 2'h3) |->
      clkIf.reqSel == fcsc_pkg::SRC_FLL) else $error("reserved source not treated as FLL");
   stopMode_a: assert property (stopMode |=> clockMode == fcsc_pkg::MODE_STOP)
      else $error("stop mode not shown");
   intByp_a: assert property ((!stopMode && !lowPowerByp &&
      st_reg.ctrlOne[fcsc_pkg::SRC_HI:fcsc_pkg::SRC_LO] == 2'h1) |=>
      clockMode == fcsc_pkg::MODE_FBI) else $error("internal bypass mode wrong");
   extByp_a: assert property ((!stopMode && !lowPowerByp &&
      st_reg.ctrlOne[fcsc_pkg::SRC_HI:fcsc_pkg::SRC_LO] == 2'h2) |=>
      clockMode == fcsc_pkg::MODE_FBE) else $error("external bypass mode wrong");
   engInt_a: assert property ((!stopMode && src == fcsc_pkg::SRC_FLL && internal_ref_select) |=>
      clockMode == fcsc_pkg::MODE_FEI) else $error("engaged internal mode wrong");
   engExt_a: assert property ((!stopMode && src == fcsc_pkg::SRC_FLL && !internal_ref_select) |=>
      clockMode == fcsc_pkg::MODE_FEE) else $error("engaged external mode wrong");

   // Enabled references must run outside stop
   irRun_a: assert property ((!stopMode && st_reg.ctrlOne[fcsc_pkg::IR_EN]) |=> internalRefRun)
      else $error("enabled internal ref halted");
   erRun_a: assert property ((!stopMode && st_reg.ctrlTwo[fcsc_pkg::ER_EN]) |=> extRefRun)
      else $error("enabled external ref halted");

   waitBound_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("waitrequest held too long");
   readBack_a: assert property (rdOne |-> avs_readdata[7:0] == st_reg.ctrlOne)
      else $error("read back differs");
   writeRange_a: assert property (accTwo |=> oscRangeHigh == $past(avs_writedata[5]) &&
      oscHighGain == $past(avs_writedata[4])) else $error("oscillator fields not written");
   fllPower_a: assert property ((stopMode || (bypassBoth && lowPowerByp)) |=> !fllEnable)
      else $error("FLL left on");
   fllKeep_a: assert property ((!stopMode && !st_reg.ctrlTwo[fcsc_pkg::BYP_LP]) |=> fllEnable)
      else $error("FLL switched off");
   irStop_a: assert property ((stopMode && !st_reg.ctrlOne[fcsc_pkg::IR_KEEP]) |=>
      !internalRefRun ##1 !internalRefClkOut) else $error("internal ref runs in stop");
   erStop_a: assert property ((stopMode && !st_reg.ctrlTwo[fcsc_pkg::ER_KEEP]) |=>
      !extRefRun ##1 !extRefClkOut) else $error("external ref runs in stop");
   irGate_a: assert property (internalRefClkOut |-> $past(st_reg.ctrlOne[fcsc_pkg::IR_EN]))
      else $error("internal ref out while disabled");
   erGate_a: assert property (extRefClkOut |-> $past(st_reg.ctrlTwo[fcsc_pkg::ER_EN]))
      else $error("external ref out while disabled");
   refDiv_a: assert property ((st_reg.fllEn && refTick && st_reg.refCnt >= refLim) |=>
      fllRefTick) else $error("divided reference tick missing");
   refSel_a: assert property ((st_reg.fllEn && intEdge && st_reg.intRun && internal_ref_select &&
      refLim == 7'h00) |=> fllRefTick) else $error("internal reference not used");
endmodule : fcsc_top
`default_nettype wire

// >>> inc/fcsc_pkg.sv
// Constants, types and helpers for the clock source control block
package fcsc_pkg;
   // ************************************************************
   // Register map and fields
   // ************************************************************
   localparam logic [2:0] OFF_CTRL_ONE = 3'h0;
   localparam logic [2:0] OFF_CTRL_TWO = 3'h4;
   localparam int         SRC_HI       = 7;
   localparam int         SRC_LO       = 6;
   localparam int         REFERENCE_DIVIDER_HI      = 5;
   localparam int         REFERENCE_DIVIDER_LO      = 3;
   localparam int         IREF_SEL     = 2;
   localparam int         IR_EN        = 1;
   localparam int         IR_KEEP      = 0;
   localparam int         BUS_CLOCK_DIVIDER_HI      = 7;
   localparam int         BUS_CLOCK_DIVIDER_LO      = 6;
   localparam int         RANGE_HI     = 5;
   localparam int         GAIN_HI      = 4;
   localparam int         BYP_LP       = 3;
   localparam int         EXT_SRC      = 2;
   localparam int         ER_EN        = 1;
   localparam int         ER_KEEP      = 0;
   localparam logic [7:0] CTRL_ONE_RST = 8'h04;
   localparam logic [7:0] CTRL_TWO_RST = 8'h40;
   localparam logic [9:0] FLL_MULT     = 10'h200;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      SRC_FLL  = 2'h0,
      SRC_INT  = 2'h1,
      SRC_EXT  = 2'h2,
      SRC_RSVD = 2'h3
   } fcsc_src_t;

   typedef enum logic [2:0] {
      MODE_FEI   = 3'h0,
      MODE_FEE   = 3'h1,
      MODE_FBE   = 3'h3,
      MODE_FLL_BYPASSED_EXTERNAL_LOW_POWER_MODE = 3'h2,
      MODE_FBI   = 3'h6,
      MODE_FLL_BYPASSED_INTERNAL_LOW_POWER_MODE = 3'h7,
      MODE_STOP  = 3'h4
   } fcsc_mode_t;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [6:0] div_limit(input logic [2:0] code);
      logic [7:0] pow;
      pow = 8'h01 << code;
      return 7'(pow - 8'h01);
   endfunction : div_limit

   function automatic fcsc_src_t src_of(input logic [1:0] field);
      return (field == 2'h3) ? SRC_FLL : fcsc_src_t'(field);
   endfunction : src_of
endpackage : fcsc_pkg

// >>> inc/fcsc_clk_if.sv
// Carrier between the control logic and the output clock generator
`timescale 1ns/1ns
`default_nettype none
interface fcsc_clk_if;
   fcsc_pkg::fcsc_src_t reqSel;
   logic [1:0]          reqDiv;
   logic                fllTick;
   logic                intTick;
   logic                extTick;
   logic                sysTick;
   logic                busTick;
   fcsc_pkg::fcsc_src_t actSel;

   modport ctrl (output reqSel, reqDiv, fllTick, intTick, extTick,
                 input  sysTick, busTick, actSel);
   modport gen  (input  reqSel, reqDiv, fllTick, intTick, extTick,
                 output sysTick, busTick, actSel);
endinterface : fcsc_clk_if
`default_nettype wire

// >>> src/fcsc_clk_gen.sv
// Glitch-free source switch, bus-clock divider and bus-clock halver
`timescale 1ns/1ns
`default_nettype none
module fcsc_clk_gen #(
   parameter int CNT_W = 3
) (
   input  wire logic   core_clk,
   input  wire logic   rstn,
   fcsc_clk_if.gen     clk
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      fcsc_pkg::fcsc_src_t actSel;
      logic [1:0]          actDiv;
      logic [CNT_W-1:0]    cnt;
      logic                sysTick;
      logic                busPhase;
      logic                busTick;
   } fcsc_gen_t;

   localparam fcsc_gen_t GEN_RST = '{fcsc_pkg::SRC_FLL, 2'h1, '0, 1'b0, 1'b0, 1'b0};

   fcsc_gen_t        st_reg;
   fcsc_gen_t        st_next;
   logic             srcTick;
   logic [6:0]       limFull;
   logic [CNT_W-1:0] lim;

   if (CNT_W < 3)
   begin : g_check
      $error("fcsc_clk_gen: CNT_W must be at least 3");
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      st_next = st_reg;
      st_next.sysTick = 1'b0;
      st_next.busTick = 1'b0;
      case (st_reg.actSel)
         fcsc_pkg::SRC_INT: srcTick = clk.intTick;
         fcsc_pkg::SRC_EXT: srcTick = clk.extTick;
         default:           srcTick = clk.fllTick;
      endcase
      limFull = fcsc_pkg::div_limit({1'b0, st_reg.actDiv});
      lim = limFull[CNT_W-1:0];
      // Switch only between periods, so no pulse is cut short
      // Limitation: an old source that dies mid-period holds the switch off
      if (st_reg.cnt == '0 && (clk.reqSel != st_reg.actSel || clk.reqDiv != st_reg.actDiv))
      begin
         st_next.actSel = clk.reqSel;
         st_next.actDiv = clk.reqDiv;
      end
      else if (srcTick)
      begin
         if (st_reg.cnt >= lim)
         begin
            st_next.cnt = '0;
            st_next.sysTick = 1'b1;
            st_next.busPhase = !st_reg.busPhase;
            st_next.busTick = st_reg.busPhase;
         end
         else
         begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         st_reg <= GEN_RST;
      else
         st_reg <= st_next;
   end

   assign clk.sysTick = st_reg.sysTick;
   assign clk.busTick = st_reg.busTick;
   assign clk.actSel  = st_reg.actSel;

   // ************************************************************
   // Checks
   // ************************************************************
   noReservedSrc_a: assert property (@(posedge core_clk) disable iff (!rstn)
      st_reg.actSel != fcsc_pkg::SRC_RSVD) else $error("reserved source active");
   divPeriod_a: assert property (@(posedge core_clk) disable iff (!rstn)
      clk.sysTick |-> $past(srcTick) && ($past(st_reg.cnt) == $past(lim)))
      else $error("output tick off its divide count");
   busHalf_a: assert property (@(posedge core_clk) disable iff (!rstn)
      clk.busTick |-> clk.sysTick && !st_reg.busPhase) else $error("bus tick not every second");
   switchEdge_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_reg.actSel != $past(st_reg.actSel)) |-> ($past(st_reg.cnt) == '0))
      else $error("source switched mid-period");
endmodule : fcsc_clk_gen
`default_nettype wire

// >>> verification/fcsc_ref_model.sv
// Reference oscillators and FLL stand-in facing the clock source block
`timescale 1ns/1ns
`default_nettype none
module fcsc_ref_model #(
   parameter int INT_HALF = 400,
   parameter int EXT_HALF = 600
) (
   input  wire logic core_clk,
   input  wire logic intRun,
   input  wire logic extRun,
   input  wire logic fllOn,
   output logic      intClk,
   output logic      extClk,
   output logic      fllTick
);
   // ****
   // Sources
   // ****
   initial {intClk, extClk, fllTick} = 3'h0;
   // Halted oscillator sits low, no stale edges leak out
   always #(INT_HALF) intClk = intRun ? ~intClk : 1'h0;
   always #(EXT_HALF) extClk = extRun ? ~extClk : 1'h0;
   // FLL ticks every second cycle only while enabled
   always @(posedge core_clk) fllTick <= fllOn & ~fllTick;
endmodule : fcsc_ref_model
`default_nettype wire

// >>> verification/fcsc_top_tb_top.sv
// Self-checking bench for the clock source control registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin nErrors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module fcsc_top_tb_top;
   // ****
   // Signals
   // ****
   localparam logic [2:0] A1 = fcsc_pkg::OFF_CTRL_ONE;
   localparam logic [2:0] A2 = fcsc_pkg::OFF_CTRL_TWO;
   logic        core_clk = 1'h0;
   logic        rstn = 1'h0;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'h0;
   logic        avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic        stopMode = 1'h0;
   logic        backgroundDebugActive = 1'h0;
   wire logic [31:0] avs_readdata;
   wire logic [9:0]  fllLockRatio;
   wire logic [2:0]  clockMode;
   wire logic avs_waitrequest, intRefClkIn, extRefClkIn, fllOutTick, fllRefTick, fllRefInternal,
      fllEnable, internalRefRun, internalRefClkOut, extRefRun, extRefClkOut, oscRangeHigh,
      oscHighGain, oscSelect, systemClkTick, busClkTick;
   int          nErrors = 0;
   int          checkCount = 0;
   int          cSys, cBus, cRef, cIo, cEo;
   logic [31:0] rd;
   logic [23:0] tbl [7] = '{24'h040030, 24'h044018, 24'h04800C, 24'h04C006, 24'h44000C,
                            24'h800008, 24'hC40030};
   logic [19:0] st [6] = '{20'h04400, 20'h05402, 20'h04410, 20'h04431, 20'h00411, 20'h03402};

   fcsc_top fcsc_top_inst (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .intRefClkIn, .extRefClkIn, .fllOutTick,
      .stopMode, .backgroundDebugActive, .fllRefTick, .fllRefInternal, .fllEnable, .fllLockRatio,
      .internalRefRun, .internalRefClkOut, .extRefRun, .extRefClkOut, .oscRangeHigh, .oscHighGain,
      .oscSelect, .systemClkTick, .busClkTick, .clockMode);
   fcsc_ref_model fcsc_ref_model_inst (.core_clk, .intRun(internalRefRun), .extRun(extRefRun),
      .fllOn(fllEnable), .intClk(intRefClkIn), .extClk(extRefClkIn), .fllTick(fllOutTick));

   always #50 core_clk = ~core_clk;

   // ****
   // Tasks
   // ****
   task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                         input logic [3:0] be);
      avs_address    <= a;
      avs_writedata  <= {24'h0, d};
      avs_byteenable <= be;
      avs_read       <= ~w;
      avs_write      <= w;
      do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
      @(posedge core_clk);
   endtask : access

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      access(1'h1, a, d, 4'hF);
   endtask : wr

   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      access(1'h0, a, 8'h00, 4'hF);
      `CHK("readdata", {24'h0, e}, rd)
   endtask : rdchk

   // Long settle: a switch waits for the old divider to wrap
   task automatic cfg(input logic [7:0] c1, input logic [7:0] c2);
      wr(A1, c1);
      wr(A2, c2);
      repeat (150) @(posedge core_clk);
   endtask : cfg

   // Window is a multiple of every tick period, so counts are exact
   task automatic win();
      cSys = 0;
      cBus = 0;
      cRef = 0;
      cIo = 0;
      cEo = 0;
      repeat (96)
      begin
         @(posedge core_clk);
         cSys += systemClkTick;
         cBus += busClkTick;
         cRef += fllRefTick;
         cIo += internalRefClkOut;
         cEo += extRefClkOut;
      end
   endtask : win

   task automatic conclude();
      if (nErrors == 0 && checkCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // ****
   // Tests
   // ****
   initial
   begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'h1;
      @(posedge core_clk);
      rdchk(A1, 8'h04);
      rdchk(A2, 8'h40);
      `CHK("lockRatio", 10'h200, fllLockRatio)
      wr(A2, 8'h35);
      rdchk(A2, 8'h35);
      `CHK("osc", 3'h7, {oscRangeHigh, oscHighGain, oscSelect})
      wr(A2, 8'h08);
      `CHK("osc", 3'h0, {oscRangeHigh, oscHighGain, oscSelect})
      access(1'h1, A2, 8'hFF, 4'hE);
      rdchk(A2, 8'h08);
      wr(3'h2, 8'hFF);
      rdchk(3'h2, 8'h00);
      rdchk(A1, 8'h04);
      foreach (tbl[i])
      begin
         cfg(tbl[i][23:16], tbl[i][15:8]);
         win();
         `CHK("sysTicks", tbl[i][7:0], 8'(cSys))
         `CHK("busTicks", tbl[i][7:0] >> 1, 8'(cBus))
      end
      for (int r = 0; r < 3; r++)
      begin
         cfg(8'h04 | 8'(r << 3), 8'h40);
         win();
         `CHK("refTicks", 8'(12 >> r), 8'(cRef))
         `CHK("intOut", 8'h00, 8'(cIo))
      end
      cfg(8'h00, 8'h40);
      win();
      `CHK("refTicks", 8'h08, 8'(cRef))
      `CHK("refInternal", 1'h0, fllRefInternal)
      `CHK("extOut", 8'h00, 8'(cEo))
      cfg(8'h06, 8'h42);
      win();
      `CHK("intOut", 8'h0C, 8'(cIo))
      `CHK("extOut", 8'h08, 8'(cEo))
      cfg(8'h44, 8'h08);
      `CHK("fllEnable", 1'h0, fllEnable)
      `CHK("mode", 3'h7, clockMode)
      backgroundDebugActive <= 1'h1;
      repeat (20) @(posedge core_clk);
      `CHK("fllEnable", 1'h1, fllEnable)
      `CHK("mode", 3'h6, clockMode)
      backgroundDebugActive <= 1'h0;
      foreach (st[i])
      begin
         cfg(st[i][19:12], st[i][11:4]);
         stopMode <= 1'h1;
         repeat (10) @(posedge core_clk);
         `CHK("stopRun", st[i][1:0], {internalRefRun, extRefRun})
         `CHK("stopMode", fcsc_pkg::MODE_STOP, clockMode)
         stopMode <= 1'h0;
      end
      conclude();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      nErrors++;
      conclude();
   end
endmodule : fcsc_top_tb_top
`default_nettype wire
